// ==== measurement_defs.vh ====
`ifndef MEASUREMENT_DEFS_VH
`define MEASUREMENT_DEFS_VH

// ==============================================
// Register offsets on the register port.
`define ADDR_LSB_LOW      8'h04
`define ADDR_LSB_HIGH     8'h05
`define ADDR_INT_TEMP     8'h07
`define ADDR_EXT_ANALOG_INPUT_1     8'h08
`define ADDR_ANALOG_INPUT_2         8'h09
`define ADDR_ANALOG_INPUT_3         8'h0a
`define ADDR_ANALOG_INPUT_4         8'h0b
`define ADDR_ANALOG_INPUT_5         8'h0c
`define ADDR_ANALOG_INPUT_6         8'h0d
`define ADDR_CONV_CTRL    8'h19

// ==============================================
// Conversion control fields and reset values.
`define CTRL_RESET        8'h00
`define CTRL_SOFT_RESET   7
`define CTRL_TIMEOUT_EN   6
`define CTRL_AVG_DIS      5
`define CTRL_MODE         4
`define CTRL_CHAN_HI      3
`define CTRL_CHAN_LO      0
`define RESULT_RESET      10'h000
`define READ_ZERO         8'h00

// ==============================================
// Channel codes.
`define CH_VDD            4'h0
`define CH_INT_TEMP       4'h1
`define CH_EXT_ANALOG_INPUT_1       4'h2
`define CH_ANALOG_INPUT_2           4'h3
`define CH_ANALOG_INPUT_6           4'h7
`define CH_LAST           4'h9

// ==============================================
// Averaging and timing.
`define AVG_LAST          4'hf
`define AVG_SHIFT         4
`define SCL_TIMEOUT_MS    25
`define CLK_FREQ_KHZ      100000

`endif

// ==== sample_averager.v ====
`timescale 1ns/1ps
`default_nettype none
`include "measurement_defs.vh"

module sample_averager
(
   input  wire        clk_sys,
   input  wire        reset_n,
   input  wire        clear,
   input  wire        sampleValid,
   input  wire [9:0]  sampleData,
   input  wire        avgDisable,
   output reg         avgDone,
   output reg  [9:0]  avgResult
);

   reg  [13:0] accum_q;
   reg  [3:0]  count_q;
   wire [13:0] sum;

   assign sum = accum_q + {4'h0, sampleData};

   // ==============================================
   // Sums sixteen samples, or passes each one through when averaging is off.
   always @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         accum_q   <= 14'h0000;
         count_q   <= 4'h0;
         avgDone   <= 1'b0;
         avgResult <= `RESULT_RESET;
      end
      else if (clear)
      begin
         accum_q <= 14'h0000;
         count_q <= 4'h0;
         avgDone <= 1'b0;
      end
      else if (sampleValid)
      begin
         if (avgDisable)
         begin
            avgDone   <= 1'b1;
            avgResult <= sampleData;
         end
         else if (count_q == `AVG_LAST)
         begin
            avgDone   <= 1'b1;
            avgResult <= sum[13:`AVG_SHIFT];
            accum_q   <= 14'h0000;
            count_q   <= 4'h0;
         end
         else
         begin
            avgDone <= 1'b0;
            accum_q <= sum;
            count_q <= count_q + 4'h1;
         end
      end
      else
      begin
         avgDone <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// ==== scl_timeout_monitor.v ====
`timescale 1ns/1ps
`default_nettype none
`include "measurement_defs.vh"

module scl_timeout_monitor
#(
   parameter integer CNT_W          = 22,
   parameter integer TIMEOUT_CYCLES = 2500000
)
(
   input  wire clk_sys,
   input  wire reset_n,
   input  wire sclIn,
   input  wire enable,
   input  wire syncClear,
   output reg  timeoutPulse,
   output reg  sdaRelease
);

   // The last count is cut to the counter width on purpose.
   localparam integer     LIMIT_FULL = TIMEOUT_CYCLES - 1;
   localparam [CNT_W-1:0] LIMIT      = LIMIT_FULL[CNT_W-1:0];

   reg             sclMeta_q;
   reg             sclSync_q;
   reg [CNT_W-1:0] lowCount_q;

   // ==============================================
   // Brings the serial clock pin into this clock domain.
   always @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sclMeta_q <= 1'b1;
         sclSync_q <= 1'b1;
      end
      else
      begin
         sclMeta_q <= sclIn;
         sclSync_q <= sclMeta_q;
      end
   end

   // ==============================================
   // Times a low clock pulse and abandons the transfer once it is too long.
   always @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         lowCount_q   <= {CNT_W{1'b0}};
         timeoutPulse <= 1'b0;
         sdaRelease   <= 1'b0;
      end
      else if (syncClear || !enable || sclSync_q)
      begin
         lowCount_q   <= {CNT_W{1'b0}};
         timeoutPulse <= 1'b0;
         sdaRelease   <= 1'b0;
      end
      else if (lowCount_q == LIMIT)
      begin
         timeoutPulse <= !sdaRelease;
         sdaRelease   <= 1'b1;
      end
      else
      begin
         lowCount_q   <= lowCount_q + {{(CNT_W-1){1'b0}}, 1'b1};
         timeoutPulse <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// ==== measurement_result_and_conversion_ctrl.v ====
// Overview of operation
// - Register 07h holds internal temperature bits 9:2, twos complement.
// - Register 08h holds external temperature or input 1, upper eight bits.
// - Input 2 full result is register 09h plus bits 3:2 of 04h.
// - Input 3 full result is register 0Ah plus bits 5:4 of 04h.
// - Input 4 full result is register 0Bh plus bits 7:6 of 04h.
// - Input 5 full result is register 0Ch plus bits 1:0 of 05h.
// - All result registers read zero after power-up.
// - Single-channel mode converts the channel coded in the 4-bit select field.
// - Code 0010 picks external sensor or input 1 from another register.
// - Mode bit 0 gives round robin, 1 gives single channel.
// - Sixteen-sample averaging is on unless the averaging bit is set.
// - With timeout enabled, a low clock pulse over 25 ms abandons the transfer.
// - Writing 1 to the top control bit resets all registers to defaults.
// - Register 05h holds low bit pairs of inputs 5 to 8.
`timescale 1ns/1ps
`default_nettype none
`include "measurement_defs.vh"

module measurement_result_and_conversion_ctrl
#(
   parameter integer TIMEOUT_MS     = `SCL_TIMEOUT_MS,
   parameter integer TIMEOUT_CYCLES = TIMEOUT_MS * `CLK_FREQ_KHZ,
   parameter integer CNT_W          = 22
)
(
   input  wire        clk_sys,
   input  wire        reset_n,
   input  wire [7:0]  regAddr,
   input  wire [7:0]  regWrData,
   input  wire        regWrEn,
   input  wire        regRdEn,
   output reg  [7:0]  regRdData,
   input  wire [1:0]  extInputSelect,
   output reg         convStart,
   output reg  [3:0]  convChannel,
   output reg         convUseAin1,
   input  wire        sampleValid,
   input  wire [9:0]  sampleData,
   input  wire        sclIn,
   output wire        sclTimeout,
   output wire        sdaRelease,
   output reg         softResetPulse
);

   // ==============================================
   // Sequencer states.
   localparam [1:0] S_START = 2'h0;
   localparam [1:0] S_WAIT  = 2'h1;
   localparam [1:0] S_CHECK = 2'h2;

   reg  [7:0] convCtrl_q;
   reg  [9:0] resultMem [1:`CH_LAST];
   reg  [1:0] state_q;
   reg  [3:0] chan_q;
   reg        firstSample_q;
   reg  [3:0] nextChan;
   reg  [7:0] rdData_d;
   wire       ctrlWrite;
   wire       softReset;
   wire       singleMode;
   wire       avgDisable;
   wire       timeoutEnable;
   wire [3:0] chanSelect;
   wire       avgDone;
   wire [9:0] avgResult;
   wire       avgClear;
   wire [7:0] lsbLow;
   wire [7:0] lsbHigh;
   integer    i;

   // ==============================================
   // Control field decode.
   assign ctrlWrite     = regWrEn && (regAddr == `ADDR_CONV_CTRL);
   assign softReset     = ctrlWrite && regWrData[`CTRL_SOFT_RESET];
   assign singleMode    = convCtrl_q[`CTRL_MODE];
   assign avgDisable    = convCtrl_q[`CTRL_AVG_DIS];
   assign timeoutEnable = convCtrl_q[`CTRL_TIMEOUT_EN];
   assign chanSelect    = convCtrl_q[`CTRL_CHAN_HI:`CTRL_CHAN_LO];

   // ==============================================
   // Conversion control register; the reset bit itself never stores.
   always @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         convCtrl_q <= `CTRL_RESET;
      end
      else if (softReset)
      begin
         convCtrl_q <= `CTRL_RESET;
      end
      else if (ctrlWrite)
      begin
         convCtrl_q <= {1'b0, regWrData[`CTRL_TIMEOUT_EN:`CTRL_CHAN_LO]};
      end
   end

   // ==============================================
   // One-cycle pulse to the rest of the device after a software reset.
   always @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         softResetPulse <= 1'b0;
      end
      else
      begin
         softResetPulse <= softReset;
      end
   end

   // ==============================================
   // Picks the channel after the one just finished.
   always @*
   begin
      nextChan = `CH_VDD;
      if (singleMode)
      begin
         if (chanSelect <= `CH_LAST)
         begin
            nextChan = chanSelect;
         end
         else
         begin
            nextChan = `CH_VDD;
         end
      end
      else if (chan_q != `CH_LAST)
      begin
         nextChan = chan_q + 4'h1;
      end
   end

   // ==============================================
   // Sequencer: requests samples until the averager reports a result.
   always @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_q       <= S_START;
         chan_q        <= `CH_VDD;
         firstSample_q <= 1'b1;
         convStart     <= 1'b0;
      end
      else if (softReset)
      begin
         state_q       <= S_START;
         chan_q        <= `CH_VDD;
         firstSample_q <= 1'b1;
         convStart     <= 1'b0;
      end
      else
      begin
         case (state_q)
            S_START:
            begin
               convStart <= 1'b1;
               state_q   <= S_WAIT;
            end
            S_WAIT:
            begin
               convStart <= 1'b0;
               if (sampleValid)
               begin
                  firstSample_q <= 1'b0;
                  state_q       <= S_CHECK;
               end
            end
            S_CHECK:
            begin
               if (avgDone)
               begin
                  chan_q        <= nextChan;
                  firstSample_q <= 1'b1;
               end
               state_q <= S_START;
            end
            default:
            begin
               state_q   <= S_START;
               convStart <= 1'b0;
            end
         endcase
      end
   end

   // ==============================================
   // Channel and source select presented to the converter.
   always @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         convChannel <= `CH_VDD;
         convUseAin1 <= 1'b0;
      end
      else
      begin
         convChannel <= chan_q;
         convUseAin1 <= (chan_q == `CH_EXT_ANALOG_INPUT_1) && (|extInputSelect);
      end
   end

   // ==============================================
   // The first sample of each channel restarts the sum.
   assign avgClear = softReset || (sampleValid && firstSample_q && (state_q == S_WAIT));

   sample_averager u_averager
   (
      .clk_sys     (clk_sys),
      .reset_n     (reset_n),
      .clear       (avgClear),
      .sampleValid (sampleValid && (state_q == S_WAIT) && !avgClear),
      .sampleData  (sampleData),
      .avgDisable  (avgDisable),
      .avgDone     (avgDone),
      .avgResult   (avgResult)
   );

   // ==============================================
   // Result store; VDD is kept elsewhere in the device.
   always @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         for (i = 1; i <= `CH_LAST; i = i + 1)
         begin
            resultMem[i] <= `RESULT_RESET;
         end
      end
      else if (softReset)
      begin
         for (i = 1; i <= `CH_LAST; i = i + 1)
         begin
            resultMem[i] <= `RESULT_RESET;
         end
      end
      else if ((state_q == S_CHECK) && avgDone && (chan_q != `CH_VDD))
      begin
         resultMem[chan_q] <= avgResult;
      end
   end

   // ==============================================
   // Shared low-bit registers.
   assign lsbLow  = {resultMem[5][1:0], resultMem[4][1:0],
                     resultMem[3][1:0], resultMem[2][1:0]};
   assign lsbHigh = {resultMem[9][1:0], resultMem[8][1:0],
                     resultMem[7][1:0], resultMem[6][1:0]};

   // ==============================================
   // Read decode; unmapped offsets read zero.
   always @*
   begin
      rdData_d = `READ_ZERO;
      case (regAddr)
         `ADDR_LSB_LOW:   rdData_d = lsbLow;
         `ADDR_LSB_HIGH:  rdData_d = lsbHigh;
         `ADDR_INT_TEMP:  rdData_d = resultMem[1][9:2];
         `ADDR_EXT_ANALOG_INPUT_1:  rdData_d = resultMem[2][9:2];
         `ADDR_ANALOG_INPUT_2:      rdData_d = resultMem[3][9:2];
         `ADDR_ANALOG_INPUT_3:      rdData_d = resultMem[4][9:2];
         `ADDR_ANALOG_INPUT_4:      rdData_d = resultMem[5][9:2];
         `ADDR_ANALOG_INPUT_5:      rdData_d = resultMem[6][9:2];
         `ADDR_ANALOG_INPUT_6:      rdData_d = resultMem[7][9:2];
         `ADDR_CONV_CTRL: rdData_d = convCtrl_q;
         default:         rdData_d = `READ_ZERO;
      endcase
   end

   // ==============================================
   // Read data stands only in the cycle after the strobe.
   always @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         regRdData <= `READ_ZERO;
      end
      else if (regRdEn)
      begin
         regRdData <= rdData_d;
      end
      else
      begin
         regRdData <= `READ_ZERO;
      end
   end

   // ==============================================
   // Serial clock timeout watchdog.
   scl_timeout_monitor
   #(
      .CNT_W          (CNT_W),
      .TIMEOUT_CYCLES (TIMEOUT_CYCLES)
   )
   u_timeout
   (
      .clk_sys      (clk_sys),
      .reset_n      (reset_n),
      .sclIn        (sclIn),
      .enable       (timeoutEnable),
      .syncClear    (softReset),
      .timeoutPulse (sclTimeout),
      .sdaRelease   (sdaRelease)
   );

endmodule
`default_nettype wire

// ==== meas_ctrl_checker_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port-level properties of the result and control block.
module meas_ctrl_checker
#(
   parameter integer TIMEOUT_CYCLES = 20
)
(
   input wire logic       clk_sys,
   input wire logic       reset_n,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic       regWrEn,
   input wire logic       regRdEn,
   input wire logic [7:0] regRdData,
   input wire logic       convStart,
   input wire logic [3:0] convChannel,
   input wire logic       convUseAin1,
   input wire logic       sclIn,
   input wire logic       sclTimeout,
   input wire logic       sdaRelease,
   input wire logic       softResetPulse
);
   logic [31:0] lowCnt_q;
   logic        softReq_q;
   wire         softWr = regWrEn && regAddr == 8'h19 && regWrData[7];

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);

   // Tracks how long the serial clock stayed low and whether a reset write was taken.
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         lowCnt_q <= 32'h0;
         softReq_q <= 1'b0;
      end
      else
      begin
         lowCnt_q <= sclIn ? 32'h0 : lowCnt_q + 32'h1;
         softReq_q <= softWr;
      end
   end

   // ==========================================
   // Assertions.
   rd_idle_zero_a: assert property (!$past(regRdEn) |-> regRdData == 8'h00)
      else $error("read data outside its slot");
   start_one_cycle_a: assert property (convStart |=> !convStart)
      else $error("conversion start longer than one cycle");
   soft_pulse_a: assert property (softWr |=> softResetPulse)
      else $error("no reset pulse after reset write");
   soft_cause_a: assert property (softResetPulse |-> softReq_q)
      else $error("reset pulse without reset write");
   analog_input_1_chan_a: assert property (convUseAin1 |-> convChannel == 4'h2)
      else $error("input one chosen off the shared channel");
   chan_range_a: assert property (convChannel <= 4'h9)
      else $error("channel code out of range");
   timeout_late_a: assert property (sclTimeout |-> lowCnt_q >= TIMEOUT_CYCLES)
      else $error("timeout before the clock was low long enough");
   timeout_release_a: assert property (sclTimeout |-> ##[0:1] sdaRelease)
      else $error("data line not released on timeout");
   release_end_a: assert property (sclIn [*5] |=> !sdaRelease)
      else $error("data line held released with clock high");

   cover property (sclTimeout);
   cover property (softResetPulse);
   cover property (convUseAin1);
endmodule
`default_nettype wire

// ==== conv_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Converter model: answers each start with one sample after a few cycles.
module conv_model
#(
   parameter integer DELAY = 3
)
(
   input  wire logic       clk_sys,
   input  wire logic       reset_n,
   input  wire logic       convStart,
   input  wire logic [3:0] convChannel,
   input  wire logic       convUseAin1,
   input  wire logic       jitter,
   output var  logic       sampleValid,
   output var  logic [9:0] sampleData
);
   logic [3:0] cnt_q;
   logic       tog_q;

   // Sample value follows the channel; jitter adds 4 on every other sample.
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cnt_q <= 4'h0;
         tog_q <= 1'b0;
         sampleValid <= 1'b0;
         sampleData <= 10'h000;
      end
      else
      begin
         sampleValid <= 1'b0;
         sampleData <= ~sampleData; // Data line is not held outside a sample.
         if (convStart)
            cnt_q <= DELAY[3:0];
         else if (cnt_q == 4'h1)
         begin
            cnt_q <= 4'h0;
            tog_q <= ~tog_q;
            sampleValid <= 1'b1;
            sampleData <= ({convChannel, 2'b01, convChannel} ^ {10{convUseAin1}})
               + ((jitter && tog_q) ? 10'h004 : 10'h000);
         end
         else if (cnt_q != 4'h0)
            cnt_q <= cnt_q - 4'h1;
      end
   end
endmodule
`default_nettype wire

// ==== measurement_result_and_conversion_ctrl_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Self-checking bench for the result and control block.
module measurement_result_and_conversion_ctrl_tb;
   localparam integer TO_CYC = 20;
   logic       clk_sys, reset_n, regWrEn, regRdEn, sclIn, jitter;
   logic       convStart, convUseAin1, sampleValid, sclTimeout, sdaRelease, softResetPulse;
   logic [7:0] regAddr, regWrData, regRdData, d;
   logic [1:0] extInputSelect;
   logic [3:0] convChannel;
   logic [9:0] sampleData, v;
   int         errorCnt, totalChecks, c, e, p, k, hits;

   measurement_result_and_conversion_ctrl #(.TIMEOUT_CYCLES(TO_CYC)) dut_u (.*);
   conv_model model_u (.*);

   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic final_report();
      $display("checks %0d mismatches %0d", totalChecks, errorCnt);
      if (errorCnt == 0 && totalChecks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      totalChecks++;
      if (seen !== exp)
      begin
         errorCnt++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // Register port cycles: one strobe cycle, read data in the next cycle.
   task automatic wr(input logic [7:0] a, input logic [7:0] w);
      @(posedge clk_sys);
      regAddr <= a;
      regWrData <= w;
      regWrEn <= 1'b1;
      @(posedge clk_sys);
      regWrEn <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] r);
      @(posedge clk_sys);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge clk_sys);
      regRdEn <= 1'b0;
      #1 r = regRdData;
   endtask

   // Waits for n converter samples, giving up after a bound.
   task automatic wait_samples(input int n);
      int got;
      got = 0;
      for (int i = 0; i < n * 20 && got < n; i++)
      begin
         @(posedge clk_sys);
         #1 if (sampleValid === 1'b1) got++;
      end
      if (got < n)
      begin
         errorCnt++;
         $display("mismatch at %0t: converter stalled", $time);
         final_report();
      end
   endtask

   initial
   begin
      {reset_n, regWrEn, regRdEn, jitter, errorCnt, totalChecks} = '0;
      {regAddr, regWrData, extInputSelect} = '0;
      sclIn = 1'b1;
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b1;
      for (k = 4; k < 14; k++)
      begin
         rd(k[7:0], d);
         chk(d, 8'h00);
      end
      rd(8'h19, d);
      chk(d, 8'h00);
      rd(8'h30, d);
      chk(d, 8'h00);
      wr(8'h19, 8'h78);
      rd(8'h19, d);
      chk(d, 8'h78);
      $display("test reset values done");
      // Single channel, no averaging, both sources of the shared channel.
      for (e = 0; e < 2; e++)
         for (c = 1; c < 8; c++)
         begin
            extInputSelect <= e[1:0];
            wr(8'h19, {4'h3, c[3:0]});
            wait_samples(5);
            v = {c[3:0], 2'b01, c[3:0]} ^ {10{c == 2 && e != 0}};
            rd(8'h06 + c[7:0], d);
            chk(d, v[9:2]);
            if (c > 1)
            begin
               rd((c < 6) ? 8'h04 : 8'h05, d);
               p = 2 * ((c - 2) % 4);
               chk({6'h00, d[p +: 2]}, {6'h00, v[1:0]});
            end
         end
      $display("test single channel done");
      jitter <= 1'b1;
      wr(8'h19, 8'h13);
      wait_samples(36);
      rd(8'h09, d);
      chk(d, 8'h35);
      rd(8'h04, d);
      chk({6'h00, d[3:2]}, 8'h01);
      jitter <= 1'b0;
      $display("test averaging done");
      wr(8'h19, 8'h20);
      wait_samples(30);
      rd(8'h07, d);
      chk(d, 8'h14);
      rd(8'h0d, d);
      chk(d, 8'h75);
      rd(8'h05, d);
      chk(d, 8'h4e);
      $display("test round robin done");
      wr(8'h19, 8'h80);
      #1 chk({7'h00, softResetPulse}, 8'h01);
      rd(8'h19, d);
      chk(d, 8'h00);
      rd(8'h0d, d);
      chk(d, 8'h00);
      $display("test soft reset done");
      wr(8'h19, 8'h70);
      sclIn <= 1'b0;
      for (k = 0; k < TO_CYC + 20 && sclTimeout !== 1'b1; k++)
         @(posedge clk_sys) #1;
      chk({7'h00, sclTimeout}, 8'h01);
      @(posedge clk_sys) #1 chk({7'h00, sdaRelease}, 8'h01);
      @(posedge clk_sys) sclIn <= 1'b1;
      repeat (6) @(posedge clk_sys);
      #1 chk({7'h00, sdaRelease}, 8'h00);
      wr(8'h19, 8'h30);
      sclIn <= 1'b0;
      hits = 0;
      repeat (TO_CYC + 20)
         @(posedge clk_sys) #1 if (sclTimeout !== 1'b0) hits++;
      chk(hits[7:0], 8'h00);
      sclIn <= 1'b1;
      $display("test clock timeout done");
      final_report();
   end
endmodule

bind measurement_result_and_conversion_ctrl meas_ctrl_checker
   #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk_u (.clk_sys, .reset_n, .regAddr, .regWrData,
   .regWrEn, .regRdEn, .regRdData, .convStart, .convChannel, .convUseAin1, .sclIn,
   .sclTimeout, .sdaRelease, .softResetPulse);
`default_nettype wire
